// [hdl/ddrc_pkg.sv]
`default_nettype none
package ddrc_pkg;
	localparam int P0_DW = 256;
	localparam int P1_DW = 128;
	localparam int ADDR_W = 32;
	localparam int TAG_W = 8;
	localparam int LEN_W = 8;
	localparam int MEM_DEPTH = 16;
	localparam logic [1:0] BURST_FIXED = 2'h0;
	localparam logic [1:0] BURST_WRAP = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_EXOKAY = 2'h1;
	localparam logic [1:0] LOCK_EXCL = 2'h1;
	localparam logic DIR_WRITE = 1'b1;
	// Arbitrary value, not tied to any real part
	localparam logic [6:0] CFG_DEV_ADDR = 7'h2a;
	localparam logic [7:0] CFG_CTRL_OFS = 8'h00;
	localparam logic [7:0] CFG_STAT_OFS = 8'h01;
	localparam logic [7:0] CFG_CTRL_RST = 8'h03;
	localparam logic [3:0] CFG_BYTE_BITS = 4'h8;
	typedef enum logic [1:0]
	{
		PS_IDLE = 2'b00,
		PS_WDATA = 2'b01,
		PS_WRESP = 2'b11,
		PS_RDATA = 2'b10
	} ddrc_port_state_t;
	typedef enum logic [2:0]
	{
		CS_IDLE = 3'b000,
		CS_RECV = 3'b001,
		CS_ACK = 3'b011,
		CS_SEND = 3'b010,
		CS_SACK = 3'b110
	} ddrc_cfg_state_t;
endpackage
`default_nettype wire

// [hdl/ddrc_host_ports.sv]
`timescale 1ns/100ps
`default_nettype none

module ddrc_port #(
	parameter int DW = 128,
	parameter int DEPTH = 16
)(
	input wire logic mclk, // Clock
	input wire logic rst, // Sync reset
	input wire logic enable, // Port enable from config
	input wire logic addr_dir_select, // 0 read, 1 write
	input wire logic [31:0] shared_addr, // First beat byte address
	input wire logic [1:0] shared_burst_type, // Burst type
	input wire logic [7:0] shared_addr_tag, // Transaction tag
	input wire logic [7:0] shared_burst_len, // Beats minus one
	input wire logic [1:0] shared_lock_type, // Atomic type
	input wire logic [2:0] shared_beat_size, // Log2 bytes per beat
	input wire logic shared_addr_valid, // Address valid
	output logic shared_addr_ready, // Address ready
	input wire logic [DW-1:0] wr_data, // Write data
	input wire logic [DW/8-1:0] wr_strb, // Byte strobes
	input wire logic wr_last, // Last write beat
	input wire logic wr_valid, // Write valid
	output logic wr_ready, // Write ready
	output logic [7:0] resp_tag, // Write response tag
	output logic resp_valid, // Write response valid
	input wire logic resp_ready, // Write response ready
	output logic [DW-1:0] rd_data, // Read data
	output logic [7:0] rd_tag, // Read tag
	output logic rd_last, // Last read beat
	output logic [1:0] rd_resp, // Read status
	output logic rd_valid, // Read valid
	input wire logic rd_ready, // Read ready
	output logic busy // Transaction in progress
);
	import ddrc_pkg::*;
	localparam int NB = DW / 8;
	localparam int LSB = $clog2(NB);
	localparam int IW = $clog2(DEPTH);

	logic [DW-1:0] mem [DEPTH];
	ddrc_port_state_t state, next_state;
	logic [31:0] beat_addr, next_beat_addr, step;
	logic [7:0] len, next_len, cnt, next_cnt, tag, next_tag;
	logic [2:0] size, next_size;
	logic [1:0] burst, next_burst, lock, next_lock;
	logic [DW-1:0] rdata, next_rdata;
	logic a_acc, w_beat, r_beat;

	function automatic logic [31:0] step_addr(input logic [31:0] a,
		input logic [1:0] b, input logic [2:0] s, input logic [7:0] l);
		logic [31:0] inc;
		logic [31:0] span;
		inc = 32'h1 << s;
		span = ({24'h0, l} + 32'h1) << s;
		if (b == BURST_FIXED)
			step_addr = a;
		else if (b == BURST_WRAP)
			step_addr = (a & ~(span - 32'h1)) | ((a + inc) & (span - 32'h1));
		else
			step_addr = a + inc;
	endfunction

	function automatic logic [IW-1:0] word_idx(input logic [31:0] a);
		word_idx = a[LSB +: IW];
	endfunction

	// Only idle can take an address, so one transaction runs at a time
	assign shared_addr_ready = (state == PS_IDLE) && enable;
	assign a_acc = shared_addr_valid && shared_addr_ready;
	assign wr_ready = (state == PS_WDATA);
	assign w_beat = wr_valid && wr_ready;
	assign resp_valid = (state == PS_WRESP);
	assign rd_valid = (state == PS_RDATA);
	assign r_beat = rd_valid && rd_ready;
	assign rd_last = (cnt == len);
	assign rd_data = rdata;
	assign rd_tag = tag;
	assign resp_tag = tag;
	assign rd_resp = (lock == LOCK_EXCL) ? RESP_EXOKAY : RESP_OKAY;
	assign busy = (state != PS_IDLE);
	assign step = step_addr(beat_addr, burst, size, len);

	always_comb
	begin
		next_state = state;
		next_beat_addr = beat_addr;
		next_len = len;
		next_cnt = cnt;
		next_tag = tag;
		next_size = size;
		next_burst = burst;
		next_lock = lock;
		next_rdata = rdata;
		case (state)
			PS_IDLE:
				if (a_acc)
				begin
					next_beat_addr = shared_addr;
					next_len = shared_burst_len;
					next_size = shared_beat_size;
					next_burst = shared_burst_type;
					next_lock = shared_lock_type;
					next_tag = shared_addr_tag;
					next_cnt = 8'h0;
					if (addr_dir_select == DIR_WRITE)
						next_state = PS_WDATA;
					else
					begin
						next_state = PS_RDATA;
						next_rdata = mem[word_idx(shared_addr)];
					end
				end
			PS_WDATA:
				if (w_beat)
				begin
					next_beat_addr = step;
					next_cnt = 8'(cnt + 8'h1);
					// Burst end trusts the master's last flag
					if (wr_last)
						next_state = PS_WRESP;
				end
			PS_WRESP:
				if (resp_ready)
					next_state = PS_IDLE;
			PS_RDATA:
				if (r_beat)
				begin
					if (rd_last)
						next_state = PS_IDLE;
					else
					begin
						next_beat_addr = step;
						next_rdata = mem[word_idx(step)];
						next_cnt = 8'(cnt + 8'h1);
					end
				end
			default:
				next_state = PS_IDLE;
		endcase
	end

	// All channels sample on the one controller clock
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state <= PS_IDLE;
			beat_addr <= 32'h0;
			len <= 8'h0;
			cnt <= 8'h0;
			tag <= 8'h0;
			size <= 3'h0;
			burst <= 2'h0;
			lock <= 2'h0;
			rdata <= '0;
		end
		else
		begin
			state <= next_state;
			beat_addr <= next_beat_addr;
			len <= next_len;
			cnt <= next_cnt;
			tag <= next_tag;
			size <= next_size;
			burst <= next_burst;
			lock <= next_lock;
			rdata <= next_rdata;
		end
	end

	// Storage is not reset; contents are undefined until written
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < NB; i++)
			if (w_beat && wr_strb[i])
				mem[word_idx(beat_addr)][8*i +: 8] <= wr_data[8*i +: 8];
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_wr_acc;
		shared_addr_valid && shared_addr_ready && addr_dir_select;
	endsequence
	sequence s_rd_acc;
		shared_addr_valid && shared_addr_ready && !addr_dir_select;
	endsequence

	a_wr_accept_dir: assert property (s_wr_acc |=>
		wr_ready && !rd_valid)
		else $error("write address did not open write data");
	a_rd_accept_tag: assert property (s_rd_acc |=> rd_valid
		&& rd_tag == $past(shared_addr_tag))
		else $error("read tag not taken from address");
	a_ready_gated: assert property (!enable || busy |->
		!shared_addr_ready)
		else $error("address ready while unable to accept");
	a_resp_hold: assert property (resp_valid && !resp_ready
		|=> resp_valid && $stable(resp_tag))
		else $error("write response dropped before ready");
	a_rd_hold: assert property (rd_valid && !rd_ready
		|=> rd_valid && $stable(rd_data) && $stable(rd_last))
		else $error("read beat changed before ready");
	a_wr_last_resp: assert property (w_beat && wr_last |=> resp_valid[*1]
		##0 resp_tag == $past(tag))
		else $error("no response after last write beat");
	a_rd_single: assert property (s_rd_acc and shared_burst_len == 8'h0
		|=> rd_last ##1 (!rd_valid || rd_last))
		else $error("single beat read not marked last");
	a_rd_end: assert property (r_beat && rd_last |=> !rd_valid)
		else $error("read kept going after last beat");
	a_incr_step: assert property (r_beat && !rd_last && burst == 2'h1
		|=> beat_addr == $past(beat_addr) + (32'h1 << $past(size)))
		else $error("incrementing beat address wrong");
	a_rd_status: assert property (rd_valid |-> rd_resp ==
		((lock == LOCK_EXCL) ? RESP_EXOKAY : RESP_OKAY))
		else $error("read status does not follow lock type");
endmodule

// Function
// - Serial calibration bus reads and writes configuration registers.
// - One shared address channel; type bit low reads, high writes.
// - Controller steps each beat address from burst type and size.
// - 8-bit tag travels with each address, read or write by type.
// - Address ready only when acceptable; transfer when valid and ready.
// - Read data 256 bits on port 0, 128 bits on port 1.
// - One strobe per byte lane; only strobed lanes are written.
// - Write beat transfers when write valid and write ready both high.
// - Response carries write address tag; valid held until response ready.
// - Controller marks final read beat with read last.
// - Each read beat carries the read transaction's 8-bit tag.
// - Each read beat carries a 2-bit status code.
// - Read beat completes only when valid and ready both high.
module ddrc_host_ports (
	input wire logic mclk, // 50 MHz clock
	input wire logic rst, // Sync reset, active high
	input wire logic cfg_scl_in, // Calibration bus clock pin
	input wire logic cfg_sda_in, // Calibration bus data pin
	output logic cfg_sda_out, // Data driven when enabled
	output logic cfg_sda_oe, // High while pulling data low
	input wire logic p0_addr_dir_select, // Port 0 read/write
	input wire logic [31:0] p0_shared_addr, // Port 0 address
	input wire logic [1:0] p0_shared_burst_type, // Port 0 burst type
	input wire logic [7:0] p0_shared_addr_tag, // Port 0 tag
	input wire logic [7:0] p0_shared_burst_len, // Port 0 length
	input wire logic [1:0] p0_shared_lock_type, // Port 0 lock
	input wire logic [2:0] p0_shared_beat_size, // Port 0 size
	input wire logic p0_shared_addr_valid, // Port 0 address valid
	output logic p0_shared_addr_ready, // Port 0 address ready
	input wire logic [ddrc_pkg::P0_DW-1:0] p0_wr_data, // Port 0 wdata
	input wire logic [ddrc_pkg::P0_DW/8-1:0] p0_wr_strb, // Port 0 strobes
	input wire logic [7:0] p0_wr_tag, // Port 0 write tag
	input wire logic p0_wr_last, // Port 0 write last
	input wire logic p0_wr_valid, // Port 0 write valid
	output logic p0_wr_ready, // Port 0 write ready
	output logic [7:0] p0_resp_tag, // Port 0 response tag
	output logic p0_resp_valid, // Port 0 response valid
	input wire logic p0_resp_ready, // Port 0 response ready
	output logic [ddrc_pkg::P0_DW-1:0] p0_rd_data, // Port 0 rdata
	output logic [7:0] p0_rd_tag, // Port 0 read tag
	output logic p0_rd_last, // Port 0 read last
	output logic [1:0] p0_rd_resp, // Port 0 read status
	output logic p0_rd_valid, // Port 0 read valid
	input wire logic p0_rd_ready, // Port 0 read ready
	input wire logic p1_addr_dir_select, // Port 1 read/write
	input wire logic [31:0] p1_shared_addr, // Port 1 address
	input wire logic [1:0] p1_shared_burst_type, // Port 1 burst type
	input wire logic [7:0] p1_shared_addr_tag, // Port 1 tag
	input wire logic [7:0] p1_shared_burst_len, // Port 1 length
	input wire logic [1:0] p1_shared_lock_type, // Port 1 lock
	input wire logic [2:0] p1_shared_beat_size, // Port 1 size
	input wire logic p1_shared_addr_valid, // Port 1 address valid
	output logic p1_shared_addr_ready, // Port 1 address ready
	input wire logic [ddrc_pkg::P1_DW-1:0] p1_wr_data, // Port 1 wdata
	input wire logic [ddrc_pkg::P1_DW/8-1:0] p1_wr_strb, // Port 1 strobes
	input wire logic [7:0] p1_wr_tag, // Port 1 write tag
	input wire logic p1_wr_last, // Port 1 write last
	input wire logic p1_wr_valid, // Port 1 write valid
	output logic p1_wr_ready, // Port 1 write ready
	output logic [7:0] p1_resp_tag, // Port 1 response tag
	output logic p1_resp_valid, // Port 1 response valid
	input wire logic p1_resp_ready, // Port 1 response ready
	output logic [ddrc_pkg::P1_DW-1:0] p1_rd_data, // Port 1 rdata
	output logic [7:0] p1_rd_tag, // Port 1 read tag
	output logic p1_rd_last, // Port 1 read last
	output logic [1:0] p1_rd_resp, // Port 1 read status
	output logic p1_rd_valid, // Port 1 read valid
	input wire logic p1_rd_ready // Port 1 read ready
);
	import ddrc_pkg::*;

	ddrc_cfg_state_t cstate, next_cstate;
	logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	logic [7:0] shreg, next_shreg, ptr, next_ptr, ctrl, next_ctrl;
	logic [3:0] bitcnt, next_bitcnt;
	logic [1:0] byteno, next_byteno;
	logic rw, next_rw, acked, next_acked, oe, next_oe;
	logic start, stop, scl_rise, scl_fall, busy0, busy1;

	function automatic logic [7:0] cfg_read(input logic [7:0] p,
		input logic [7:0] c, input logic b0, input logic b1);
		if (p == CFG_CTRL_OFS)
			cfg_read = c;
		else if (p == CFG_STAT_OFS)
			cfg_read = {6'h0, b1, b0};
		else
			cfg_read = 8'h00;
	endfunction

	// Write tags are not checked; responses reuse the address tag
	assign cfg_sda_out = 1'b0;
	assign cfg_sda_oe = oe;
	assign start = scl_s2 && sda_d && !sda_s2;
	assign stop = scl_s2 && !sda_d && sda_s2;
	assign scl_rise = scl_s2 && !scl_d;
	assign scl_fall = !scl_s2 && scl_d;

	always_comb
	begin
		next_cstate = cstate;
		next_shreg = shreg;
		next_ptr = ptr;
		next_ctrl = ctrl;
		next_bitcnt = bitcnt;
		next_byteno = byteno;
		next_rw = rw;
		next_acked = acked;
		if (start)
		begin
			next_cstate = CS_RECV;
			next_bitcnt = 4'h0;
			next_byteno = 2'h0;
		end
		else if (stop)
			next_cstate = CS_IDLE;
		else
			case (cstate)
				CS_RECV:
					if (scl_rise)
					begin
						next_shreg = {shreg[6:0], sda_s2};
						next_bitcnt = 4'(bitcnt + 4'h1);
					end
					else if (scl_fall && bitcnt == CFG_BYTE_BITS)
					begin
						next_bitcnt = 4'h0;
						next_cstate = CS_ACK;
						if (byteno == 2'h0)
						begin
							next_rw = shreg[0];
							if (shreg[7:1] != CFG_DEV_ADDR)
								next_cstate = CS_IDLE;
						end
						else if (byteno == 2'h1)
							next_ptr = shreg;
						else
						begin
							if (ptr == CFG_CTRL_OFS)
								next_ctrl = shreg;
							next_ptr = 8'(ptr + 8'h1);
						end
					end
				CS_ACK:
					if (scl_fall)
					begin
						next_byteno = (byteno == 2'h2) ? byteno : 2'(byteno + 2'h1);
						next_bitcnt = 4'h0;
						if (rw)
						begin
							next_cstate = CS_SEND;
							next_shreg = cfg_read(ptr, ctrl, busy0, busy1);
						end
						else
							next_cstate = CS_RECV;
					end
				CS_SEND:
					if (scl_fall)
					begin
						if (bitcnt == 4'h7)
						begin
							next_cstate = CS_SACK;
							next_ptr = 8'(ptr + 8'h1);
						end
						else
						begin
							next_shreg = {shreg[6:0], 1'b0};
							next_bitcnt = 4'(bitcnt + 4'h1);
						end
					end
				CS_SACK:
					if (scl_rise)
						next_acked = !sda_s2;
					else if (scl_fall)
					begin
						next_bitcnt = 4'h0;
						next_shreg = cfg_read(ptr, ctrl, busy0, busy1);
						next_cstate = acked ? CS_SEND : CS_IDLE;
					end
				default:
					next_cstate = CS_IDLE;
			endcase
		// Drive from the next state so the pin moves with the state
		next_oe = (next_cstate == CS_ACK) ||
			(next_cstate == CS_SEND && !next_shreg[7]);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
			cstate <= CS_IDLE;
			shreg <= 8'h0;
			ptr <= 8'h0;
			ctrl <= CFG_CTRL_RST;
			bitcnt <= 4'h0;
			byteno <= 2'h0;
			rw <= 1'b0;
			acked <= 1'b0;
			oe <= 1'b0;
		end
		else
		begin
			scl_s1 <= cfg_scl_in;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= cfg_sda_in;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
			cstate <= next_cstate;
			shreg <= next_shreg;
			ptr <= next_ptr;
			ctrl <= next_ctrl;
			bitcnt <= next_bitcnt;
			byteno <= next_byteno;
			rw <= next_rw;
			acked <= next_acked;
			oe <= next_oe;
		end
	end

	a_cfg_ack_drive: assert property (@(posedge mclk) disable iff (rst)
		cstate == CS_ACK |-> cfg_sda_oe)
		else $error("calibration bus acknowledge not driven");

	ddrc_port #(.DW(P0_DW), .DEPTH(MEM_DEPTH)) u_port0 (
		.mclk(mclk), .rst(rst), .enable(ctrl[0]),
		.addr_dir_select(p0_addr_dir_select),
		.shared_addr(p0_shared_addr),
		.shared_burst_type(p0_shared_burst_type),
		.shared_addr_tag(p0_shared_addr_tag),
		.shared_burst_len(p0_shared_burst_len),
		.shared_lock_type(p0_shared_lock_type),
		.shared_beat_size(p0_shared_beat_size),
		.shared_addr_valid(p0_shared_addr_valid),
		.shared_addr_ready(p0_shared_addr_ready),
		.wr_data(p0_wr_data), .wr_strb(p0_wr_strb), .wr_last(p0_wr_last),
		.wr_valid(p0_wr_valid), .wr_ready(p0_wr_ready),
		.resp_tag(p0_resp_tag), .resp_valid(p0_resp_valid),
		.resp_ready(p0_resp_ready), .rd_data(p0_rd_data),
		.rd_tag(p0_rd_tag), .rd_last(p0_rd_last), .rd_resp(p0_rd_resp),
		.rd_valid(p0_rd_valid), .rd_ready(p0_rd_ready), .busy(busy0)
	);

	ddrc_port #(.DW(P1_DW), .DEPTH(MEM_DEPTH)) u_port1 (
		.mclk(mclk), .rst(rst), .enable(ctrl[1]),
		.addr_dir_select(p1_addr_dir_select),
		.shared_addr(p1_shared_addr),
		.shared_burst_type(p1_shared_burst_type),
		.shared_addr_tag(p1_shared_addr_tag),
		.shared_burst_len(p1_shared_burst_len),
		.shared_lock_type(p1_shared_lock_type),
		.shared_beat_size(p1_shared_beat_size),
		.shared_addr_valid(p1_shared_addr_valid),
		.shared_addr_ready(p1_shared_addr_ready),
		.wr_data(p1_wr_data), .wr_strb(p1_wr_strb), .wr_last(p1_wr_last),
		.wr_valid(p1_wr_valid), .wr_ready(p1_wr_ready),
		.resp_tag(p1_resp_tag), .resp_valid(p1_resp_valid),
		.resp_ready(p1_resp_ready), .rd_data(p1_rd_data),
		.rd_tag(p1_rd_tag), .rd_last(p1_rd_last), .rd_resp(p1_rd_resp),
		.rd_valid(p1_rd_valid), .rd_ready(p1_rd_ready), .busy(busy1)
	);
endmodule
`default_nettype wire

// [tb/ddrc_fabric_master.sv]
`timescale 1ns/100ps
`default_nettype none
// Released address and write data go inverted, never left stale
module ddrc_fabric_master #(
	parameter int DW = 128
)(
	input wire logic mclk, // Clock
	output logic addr_dir_select = 1'b0, // 0 read, 1 write
	output logic [31:0] shared_addr = '0, // First beat address
	output logic [1:0] shared_burst_type = '0, // Burst type
	output logic [7:0] shared_addr_tag = '0, // Tag
	output logic [7:0] shared_burst_len = '0, // Beats minus one
	output logic [1:0] shared_lock_type = '0, // Lock
	output logic [2:0] shared_beat_size = '0, // Size
	output logic shared_addr_valid = 1'b0, // Address valid
	input wire logic shared_addr_ready, // Address ready
	output logic [DW-1:0] wr_data = '0, // Write data
	output logic [DW/8-1:0] wr_strb = '0, // Strobes
	output logic [7:0] wr_tag = '0, // Write tag
	output logic wr_last = 1'b0, // Last beat
	output logic wr_valid = 1'b0, // Write valid
	input wire logic wr_ready, // Write ready
	input wire logic [7:0] resp_tag, // Response tag
	input wire logic resp_valid, // Response valid
	output logic resp_ready = 1'b0, // Response ready
	input wire logic [DW-1:0] rd_data, // Read data
	input wire logic [7:0] rd_tag, // Read tag
	input wire logic rd_last, // Read last
	input wire logic [1:0] rd_resp, // Read status
	input wire logic rd_valid, // Read valid
	output logic rd_ready = 1'b0 // Read ready
);
	task automatic addr_phase(input logic dir, input logic [31:0] a,
		input logic [1:0] bt, lk, input logic [2:0] sz,
		input logic [7:0] len, tg);
		int n;
		n = 0;
		@(posedge mclk);
		addr_dir_select <= dir;
		shared_addr <= a;
		shared_burst_type <= bt;
		shared_lock_type <= lk;
		shared_beat_size <= sz;
		shared_burst_len <= len;
		shared_addr_tag <= tg;
		shared_addr_valid <= 1'b1;
		@(negedge mclk);
		while (shared_addr_ready !== 1'b1 && n < 500)
		begin
			@(negedge mclk);
			n++;
		end
		@(posedge mclk);
		shared_addr_valid <= 1'b0;
		shared_addr <= ~a;
	endtask

	task automatic wr(input logic [31:0] a, input logic [1:0] bt,
		input logic [2:0] sz, input logic [7:0] len, tg,
		input logic [255:0] d[$], input logic [31:0] s[$],
		output logic [7:0] rt);
		int n;
		addr_phase(1'b1, a, bt, 2'h0, sz, len, tg);
		for (int i = 0; i <= len; i++)
		begin
			if (i > 0)
				@(posedge mclk);
			wr_valid <= 1'b1;
			wr_data <= d[i][DW-1:0];
			wr_strb <= s[i][DW/8-1:0];
			wr_tag <= tg;
			wr_last <= (i == len);
			n = 0;
			@(negedge mclk);
			while (wr_ready !== 1'b1 && n < 500)
			begin
				@(negedge mclk);
				n++;
			end
		end
		@(posedge mclk);
		wr_valid <= 1'b0;
		wr_data <= ~wr_data;
		repeat ($urandom_range(3, 0)) @(posedge mclk);
		resp_ready <= 1'b1;
		n = 0;
		@(negedge mclk);
		while (resp_valid !== 1'b1 && n < 500)
		begin
			@(negedge mclk);
			n++;
		end
		rt = resp_tag;
		@(posedge mclk);
		resp_ready <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [1:0] bt, lk,
		input logic [2:0] sz, input logic [7:0] len, tg,
		output logic [255:0] d[$], output logic [10:0] inf[$]);
		int n;
		d = {};
		inf = {};
		n = 0;
		addr_phase(1'b0, a, bt, lk, sz, len, tg);
		while (inf.size() <= len && n < 2000)
		begin
			rd_ready <= 1'($urandom_range(1, 0));
			@(negedge mclk);
			if (rd_valid === 1'b1 && rd_ready === 1'b1)
			begin
				d.push_back(256'(rd_data));
				inf.push_back({rd_tag, rd_last, rd_resp});
			end
			@(posedge mclk);
			n++;
		end
		rd_ready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb/test_ddr_controller_axi_host_ports.sv]
`timescale 1ns/100ps
`default_nettype none
module test_ddr_controller_axi_host_ports;
	import ddrc_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	// Open-drain data line with pull-up
	logic cfg_scl_in = 1'b1;
	logic sda_drv = 1'b1;
	logic cfg_sda_out, cfg_sda_oe;
	wire cfg_sda_in = sda_drv && !cfg_sda_oe;
	logic p0_addr_dir_select, p0_shared_addr_valid, p0_shared_addr_ready;
	logic [31:0] p0_shared_addr;
	logic [1:0] p0_shared_burst_type, p0_shared_lock_type, p0_rd_resp;
	logic [7:0] p0_shared_addr_tag, p0_shared_burst_len, p0_wr_tag;
	logic [7:0] p0_resp_tag, p0_rd_tag;
	logic [2:0] p0_shared_beat_size;
	logic [P0_DW-1:0] p0_wr_data, p0_rd_data;
	logic [P0_DW/8-1:0] p0_wr_strb;
	logic p0_wr_last, p0_wr_valid, p0_wr_ready, p0_resp_valid, p0_resp_ready;
	logic p0_rd_last, p0_rd_valid, p0_rd_ready;
	logic p1_addr_dir_select, p1_shared_addr_valid, p1_shared_addr_ready;
	logic [31:0] p1_shared_addr;
	logic [1:0] p1_shared_burst_type, p1_shared_lock_type, p1_rd_resp;
	logic [7:0] p1_shared_addr_tag, p1_shared_burst_len, p1_wr_tag;
	logic [7:0] p1_resp_tag, p1_rd_tag;
	logic [2:0] p1_shared_beat_size;
	logic [P1_DW-1:0] p1_wr_data, p1_rd_data;
	logic [P1_DW/8-1:0] p1_wr_strb;
	logic p1_wr_last, p1_wr_valid, p1_wr_ready, p1_resp_valid, p1_resp_ready;
	logic p1_rd_last, p1_rd_valid, p1_rd_ready;
	logic [255:0] mem [2][16];
	int failures = 0;
	int tests_run = 0;

	ddrc_host_ports dut_u (.mclk, .rst, .cfg_scl_in, .cfg_sda_in,
		.cfg_sda_out, .cfg_sda_oe, .p0_addr_dir_select, .p0_shared_addr,
		.p0_shared_burst_type, .p0_shared_addr_tag, .p0_shared_burst_len,
		.p0_shared_lock_type, .p0_shared_beat_size, .p0_shared_addr_valid,
		.p0_shared_addr_ready, .p0_wr_data, .p0_wr_strb, .p0_wr_tag,
		.p0_wr_last, .p0_wr_valid, .p0_wr_ready, .p0_resp_tag, .p0_resp_valid,
		.p0_resp_ready, .p0_rd_data, .p0_rd_tag, .p0_rd_last, .p0_rd_resp,
		.p0_rd_valid, .p0_rd_ready, .p1_addr_dir_select, .p1_shared_addr,
		.p1_shared_burst_type, .p1_shared_addr_tag, .p1_shared_burst_len,
		.p1_shared_lock_type, .p1_shared_beat_size, .p1_shared_addr_valid,
		.p1_shared_addr_ready, .p1_wr_data, .p1_wr_strb, .p1_wr_tag,
		.p1_wr_last, .p1_wr_valid, .p1_wr_ready, .p1_resp_tag, .p1_resp_valid,
		.p1_resp_ready, .p1_rd_data, .p1_rd_tag, .p1_rd_last, .p1_rd_resp,
		.p1_rd_valid, .p1_rd_ready);

	ddrc_fabric_master #(.DW(P0_DW)) m0 (.mclk(mclk),
		.addr_dir_select(p0_addr_dir_select), .shared_addr(p0_shared_addr),
		.shared_burst_type(p0_shared_burst_type),
		.shared_addr_tag(p0_shared_addr_tag),
		.shared_burst_len(p0_shared_burst_len),
		.shared_lock_type(p0_shared_lock_type),
		.shared_beat_size(p0_shared_beat_size),
		.shared_addr_valid(p0_shared_addr_valid),
		.shared_addr_ready(p0_shared_addr_ready), .wr_data(p0_wr_data),
		.wr_strb(p0_wr_strb), .wr_tag(p0_wr_tag), .wr_last(p0_wr_last),
		.wr_valid(p0_wr_valid), .wr_ready(p0_wr_ready),
		.resp_tag(p0_resp_tag), .resp_valid(p0_resp_valid),
		.resp_ready(p0_resp_ready), .rd_data(p0_rd_data), .rd_tag(p0_rd_tag),
		.rd_last(p0_rd_last), .rd_resp(p0_rd_resp), .rd_valid(p0_rd_valid),
		.rd_ready(p0_rd_ready));

	ddrc_fabric_master #(.DW(P1_DW)) m1 (.mclk(mclk),
		.addr_dir_select(p1_addr_dir_select), .shared_addr(p1_shared_addr),
		.shared_burst_type(p1_shared_burst_type),
		.shared_addr_tag(p1_shared_addr_tag),
		.shared_burst_len(p1_shared_burst_len),
		.shared_lock_type(p1_shared_lock_type),
		.shared_beat_size(p1_shared_beat_size),
		.shared_addr_valid(p1_shared_addr_valid),
		.shared_addr_ready(p1_shared_addr_ready), .wr_data(p1_wr_data),
		.wr_strb(p1_wr_strb), .wr_tag(p1_wr_tag), .wr_last(p1_wr_last),
		.wr_valid(p1_wr_valid), .wr_ready(p1_wr_ready),
		.resp_tag(p1_resp_tag), .resp_valid(p1_resp_valid),
		.resp_ready(p1_resp_ready), .rd_data(p1_rd_data), .rd_tag(p1_rd_tag),
		.rd_last(p1_rd_last), .rd_resp(p1_rd_resp), .rd_valid(p1_rd_valid),
		.rd_ready(p1_rd_ready));

	function automatic logic [31:0] beat_addr(logic [31:0] a, logic [1:0] bt,
		logic [2:0] sz, logic [7:0] len, int i);
		logic [31:0] tot;
		logic [31:0] base;
		tot = (32'(len) + 32'h1) << sz;
		base = a - (a % tot);
		if (bt == BURST_FIXED)
			return a;
		if (bt == BURST_WRAP)
			return base + ((a - base + (i << sz)) % tot);
		return a + (i << sz);
	endfunction

	function automatic logic [255:0] rnd256();
		logic [255:0] x;
		for (int k = 0; k < 8; k++)
			x[32*k+:32] = $urandom;
		return x;
	endfunction

	task automatic chk_data(string nm, logic [255:0] e, logic [255:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_ctl(string nm, logic [10:0] e, logic [10:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cfg_pins(logic c, logic d);
		cfg_scl_in <= c;
		sda_drv <= d;
		repeat (8) @(posedge mclk);
	endtask

	task automatic cfg_byte(logic [8:0] v);
		for (int k = 8; k >= 0; k--)
		begin
			cfg_pins(1'b0, v[k]);
			cfg_pins(1'b1, v[k]);
		end
		chk_ctl("cfg_ack", 11'h1, 11'(cfg_sda_oe));
	endtask

	task automatic run_port(int p);
		logic [255:0] d[$];
		logic [31:0] s[$];
		logic [10:0] inf[$];
		logic [255:0] mask;
		logic [31:0] a;
		logic [1:0] bt, lk;
		logic [2:0] sz;
		logic [7:0] len, tg, rt;
		int lsb, w;
		lsb = p ? 4 : 5;
		mask = p ? {128'h0, {128{1'b1}}} : '1;
		for (int t = 0; t < 30; t++)
		begin
			// First pass fills every word so later reads are fully known
			bt = (t == 0) ? 2'h1 : 2'($urandom_range(2, 0));
			sz = (t == 0) ? 3'(lsb) : 3'($urandom_range(lsb, 0));
			len = 8'($urandom_range(7, 0));
			if (bt == BURST_WRAP)
				len = 8'((2 << $urandom_range(2, 0)) - 1);
			if (t == 0)
				len = 8'h0f;
			a = (t == 0) ? 32'h0 : ($urandom & 32'h3ff) & ~((32'h1 << sz) - 1);
			tg = 8'($urandom);
			lk = 2'($urandom_range(1, 0));
			if (t == 0 || t % 2 == 1)
			begin
				d = {};
				s = {};
				for (int i = 0; i <= len; i++)
				begin
					d.push_back(rnd256());
					s.push_back((t == 0) ? 32'hffffffff : $urandom);
					w = int'((beat_addr(a, bt, sz, len, i) >> lsb) & 32'hf);
					for (int b = 0; b < (p ? 16 : 32); b++)
						if (s[i][b])
							mem[p][w][8*b+:8] = d[i][8*b+:8];
				end
				if (p)
					m1.wr(a, bt, sz, len, tg, d, s, rt);
				else
					m0.wr(a, bt, sz, len, tg, d, s, rt);
				chk_ctl("resp_tag", 11'(tg), 11'(rt));
			end
			else
			begin
				if (p)
					m1.rd(a, bt, lk, sz, len, tg, d, inf);
				else
					m0.rd(a, bt, lk, sz, len, tg, d, inf);
				chk_ctl("beats", 11'(len) + 11'h1, 11'(inf.size()));
				for (int i = 0; i <= len && i < inf.size(); i++)
				begin
					w = int'((beat_addr(a, bt, sz, len, i) >> lsb) & 32'hf);
					chk_data("rd_data", mem[p][w] & mask, d[i]);
					chk_ctl("rd_info", {tg, 1'(i == len),
						((lk == LOCK_EXCL) ? RESP_EXOKAY : RESP_OKAY)},
						inf[i]);
				end
			end
		end
	endtask

	task automatic results();
		if (failures == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		forever #10 mclk = ~mclk;
	end

	initial
	begin
		#200000;
		failures++;
		results();
	end

	initial
	begin
		void'($urandom(63786));
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk_ctl("p0_idle", 11'h10, {6'h0, p0_shared_addr_ready, p0_wr_ready,
			p0_resp_valid, p0_rd_valid, cfg_sda_oe});
		chk_ctl("p1_idle", 11'h10, {6'h0, p1_shared_addr_ready, p1_wr_ready,
			p1_resp_valid, p1_rd_valid, cfg_sda_oe});
		fork
			run_port(0);
			run_port(1);
		join
		chk_ctl("sda_oe", 11'h0, {10'h0, cfg_sda_oe});
		cfg_pins(1'b1, 1'b0);
		cfg_byte({CFG_DEV_ADDR, 2'b01});
		cfg_byte({CFG_CTRL_OFS, 1'b1});
		cfg_byte({8'h02, 1'b1});
		cfg_pins(1'b0, 1'b0);
		cfg_pins(1'b1, 1'b0);
		cfg_pins(1'b1, 1'b1);
		chk_ctl("enables", 11'h1, {9'h0, p0_shared_addr_ready,
			p1_shared_addr_ready});
		results();
	end
endmodule
`default_nettype wire
